// ### upcr_bank.sv
/*
  Upconverter control register bank behind the serial I/O port, with the
  settings it drives: reference clock block, DAC code, automatic update
  timer, RAM segment 0, sync validation latch and the data assembler.
  Assumes a host clocks the serial port far slower than clk, and that the
  pins and the first control word bits arrive from outside clk's domain.
*/
// What this block does
// RQ1: Pairing bit 1 takes Q first
// RQ2: Pairing bit 0, default, takes I first
// RQ3: Hold setting ignored in operating mode 01b
// RQ4: Hold 0: standby drives zeros
// RQ5: Hold 1: standby keeps last sample
// RQ6: Gate polarity bit swaps standby and transmit
// RQ7: Validation on: error latched until disabled
// RQ8: Validation off, default: error held low
// RQ9: Third control word at address 02h
// RQ10: Bits 29:28 reference drive, reset 01b
// RQ11: Bits 26:24 oscillator band, reset 111b
// RQ12: Bits 21:19 pump current, reset 111b
// RQ13: Bit 15 bypasses input divider, reset 0
// RQ14: Bit 14 low resets divider, reset 1
// RQ15: Bit 8 enables PLL, reset 0
// RQ16: Bits 7:1 feedback modulus, reset zero
// RQ17: Address 03h bits 7:0 full-scale, FFh
// RQ18: Interval at 04h effective on write
// RQ19: Interval resets 0FFFFFFFh, needs bit 23
// RQ20: Segment 0 six bytes, 05h, immediate
// RQ21: Segment applied on RAM enable, trigger rise
// RQ22: Segment step, end and start fields
// RQ23: Segment bits 2:0 playback mode
// RQ24: Open bits read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
module upcr_bank
  import upcr_pkg::*;
#(
  parameter int DATA_W = 18  // Sample word width
) (
  input wire logic clk,
  input wire logic sys_rst,
  // Serial I/O port
  input wire logic cs_n_pin,              // Chip select, active low
  input wire logic sclk_pin,              // Serial clock
  input wire logic sdio_in,               // Serial data in
  output logic sdio_out,                  // Serial data out
  output logic sdio_oe,                   // High while driving sdio
  input wire logic io_update_pin,         // Transfer buffers to active
  // Device pins
  input wire logic transmit_gate_pin,
  input wire logic ram_trigger_pin,
  output logic sync_sample_error_pin,
  // Settings from the first control word, and the sync check result
  input wire logic [1:0] cw1_op_mode,     // Operating mode field
  input wire logic cw1_ram_enable,        // RAM enable bit
  input wire logic sync_check_fail,       // Setup/hold check result
  // Sample stream
  input wire logic [DATA_W-1:0] word_in,
  input wire logic word_valid,
  output logic [DATA_W-1:0] bb_i,
  output logic [DATA_W-1:0] bb_q,
  output logic bb_valid,
  // Reference clock and DAC settings
  output logic [1:0] reference_output_drive,
  output logic [2:0] oscillator_band_select,
  output logic [2:0] pump_current_select,
  output logic ref_div_bypass,
  output logic ref_div_run,
  output logic pll_enable,
  output logic [6:0] pll_modulus,
  output logic [7:0] dac_full_scale_code,
  // Update and RAM segment outputs
  output logic io_update_event,           // One-cycle update pulse
  output logic ram_seg0_apply,            // One-cycle segment apply
  output logic [15:0] ram_step_rate,
  output logic [9:0] ram_end_addr,
  output logic [9:0] ram_start_addr,
  output logic [2:0] ram_play_mode
);
  localparam int CNT_W = 6;  // Counts instruction plus 48 data bits

  // Two-stage synchronisers for every pin and outside input
  logic [5:0] pin_meta;   // First stage, read only by pin_sync
  logic [5:0] pin_sync;   // Second stage
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  logic sclk_prev;        // Serial clock one cycle back
  logic upd_prev;         // Update pin one cycle back
  logic rt_prev;          // Trigger pin one cycle back
  logic cs_n, sclk, sdio, upd_s, gate_s, rt_s;
  assign {cs_n, sclk, sdio, upd_s, gate_s, rt_s} = pin_sync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= 6'h20;
      pin_sync <= 6'h20;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      pin_meta <= {cs_n_pin, sclk_pin, sdio_in, io_update_pin,
                   transmit_gate_pin, ram_trigger_pin};
      pin_sync <= pin_meta;
      mode_meta <= cw1_op_mode;
      mode_sync <= mode_meta;
    end
  end

  // Edge history kept on the second stage only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_prev <= 1'b0;
      upd_prev <= 1'b0;
      rt_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk;
      upd_prev <= upd_s;
      rt_prev <= rt_s;
    end
  end

  logic ram_en_meta, ram_en_s;  // RAM enable crossing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ram_en_meta <= 1'b0;
      ram_en_s <= 1'b0;
    end else begin
      ram_en_meta <= cw1_ram_enable;
      ram_en_s <= ram_en_meta;
    end
  end

  logic sclk_rise;
  assign sclk_rise = sclk && !sclk_prev && !cs_n;

  // Serial frame state
  logic [CNT_W-1:0] bit_cnt;    // Bits seen in this frame
  logic [7:0] instr;            // Instruction byte
  logic [REG_BITS-1:0] shift;   // Data shifter, MSB first
  logic reading;                // Read data phase
  logic [ADDR_W-1:0] addr;      // Address of current frame
  logic [ADDR_W-1:0] next_addr; // Address completed this edge
  logic [2:0] frame_len;        // Register length in bytes
  logic [CNT_W-1:0] last_bit;   // Index of final data bit
  logic [REG_BITS-1:0] next_shift;
  logic [REG_BITS-1:0] rd_word; // Read value, MSB aligned
  logic wr_commit;              // Final write bit this edge

  assign next_addr = {instr[3:0], sdio};
  assign addr = instr[ADDR_W-1:0];
  assign frame_len = (addr == ADDR_SEG0) ? LEN_SEG : LEN_WORD; // RQ20
  assign last_bit = CNT_W'(INSTR_BITS - 1) + CNT_W'({frame_len, 3'h0});
  assign next_shift = {shift[REG_BITS-2:0], sdio};
  assign wr_commit = sclk_rise && !instr[INSTR_RD_POS] && (bit_cnt == last_bit)
                     && (bit_cnt >= CNT_W'(INSTR_BITS));

  // Buffered and active registers, and the immediate ones
  logic [31:0] cw2_buf, cw2_act;   // Second control word
  logic [31:0] cw3_buf, cw3_act;   // Third control word
  logic [31:0] dac_buf, dac_act;   // Full-scale code
  logic [31:0] upd_interval;       // Effective when written
  logic [47:0] seg0;               // Effective when written

  // Read mux; unmapped addresses read zero, open bits are held zero
  always_comb begin
    rd_word = '0;
    case (next_addr)
      ADDR_CW2: rd_word = {cw2_buf, 16'h0000};
      ADDR_CW3: rd_word = {cw3_buf, 16'h0000}; // RQ9
      ADDR_DAC: rd_word = {dac_buf, 16'h0000}; // RQ17
      ADDR_UPD: rd_word = {upd_interval, 16'h0000};
      ADDR_SEG0: rd_word = seg0;
      default: rd_word = '0;
    endcase
  end

  // Frame sequencing: instruction, then data shifted in or out
  always_ff @(posedge clk) begin
    if (sys_rst || cs_n) begin
      bit_cnt <= '0;
      instr <= 8'h00;
      shift <= '0;
      reading <= 1'b0;
    end else if (sclk_rise) begin
      // Saturate so a long frame cannot wrap into a second commit
      if (bit_cnt != '1) begin
        bit_cnt <= bit_cnt + CNT_W'(1);
      end
      if (bit_cnt < CNT_W'(INSTR_BITS)) begin
        instr <= {instr[6:0], sdio};
        if (bit_cnt == CNT_W'(INSTR_BITS - 1) && instr[INSTR_RD_POS - 1]) begin
          reading <= 1'b1;
          shift <= rd_word;
        end
      end else begin
        // Read shifts out one bit per edge; writes shift in
        shift <= reading ? {shift[REG_BITS-2:0], 1'b0} : next_shift;
      end
    end
  end

  // Output data and enable; the host samples before each rising edge
  assign sdio_out = shift[REG_BITS-1];
  assign sdio_oe = reading && !cs_n;

  // Update event: pin rising edge or the automatic timer
  logic auto_pulse;
  logic upd_pulse;
  assign upd_pulse = (upd_s && !upd_prev) || auto_pulse;
  assign io_update_event = upd_pulse;

  // Buffered registers; masks keep open bits at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cw2_buf <= CW2_RST;
      cw3_buf <= CW3_RST;
      dac_buf <= DAC_RST;
    end else if (wr_commit) begin
      case (addr)
        ADDR_CW2: cw2_buf <= next_shift[31:0] & CW2_MASK; // RQ24
        ADDR_CW3: cw3_buf <= next_shift[31:0] & CW3_MASK; // RQ9
        ADDR_DAC: dac_buf <= next_shift[31:0] & DAC_MASK; // RQ17
        default: ;
      endcase
    end
  end

  // Active copies move on an update event
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cw2_act <= CW2_RST;
      cw3_act <= CW3_RST;
      dac_act <= DAC_RST;
    end else if (upd_pulse) begin
      cw2_act <= cw2_buf;
      cw3_act <= cw3_buf;
      dac_act <= dac_buf;
    end
  end

  // Immediate registers need no update event
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upd_interval <= UPD_RST; // RQ19
      seg0 <= SEG_RST;
    end else if (wr_commit) begin
      if (addr == ADDR_UPD) begin
        upd_interval <= next_shift[31:0]; // RQ18
      end
      if (addr == ADDR_SEG0) begin
        seg0 <= next_shift & SEG_MASK; // RQ20
      end
    end
  end

  // Automatic update timer; a new interval restarts it at once
  logic [31:0] upd_cnt;
  logic auto_en;
  assign auto_en = cw2_act[CW2_AUTO_UPD]; // RQ19
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upd_cnt <= UPD_RST;
      auto_pulse <= 1'b0;
    end else if (!auto_en || (wr_commit && addr == ADDR_UPD)) begin
      upd_cnt <= (wr_commit && addr == ADDR_UPD) ? next_shift[31:0] : upd_interval; // RQ18
      auto_pulse <= 1'b0;
    end else if (upd_cnt == 32'h0000_0000) begin
      upd_cnt <= upd_interval;
      auto_pulse <= 1'b1;
    end else begin
      upd_cnt <= upd_cnt - 32'h0000_0001;
      auto_pulse <= 1'b0;
    end
  end

  // Reference clock and DAC settings from the active words
  assign reference_output_drive = cw3_act[CW3_DRV_LO +: 2]; // RQ10
  assign oscillator_band_select = cw3_act[CW3_BAND_LO +: 3]; // RQ11
  assign pump_current_select = cw3_act[CW3_PUMP_LO +: 3]; // RQ12
  assign ref_div_bypass = cw3_act[CW3_DIV_BYP]; // RQ13
  assign ref_div_run = cw3_act[CW3_DIV_RUN]; // RQ14
  assign pll_enable = cw3_act[CW3_PLL_EN]; // RQ15
  assign pll_modulus = cw3_act[CW3_N_LO +: 7]; // RQ16
  assign dac_full_scale_code = dac_act[7:0]; // RQ17

  // RAM segment 0 is applied only on a trigger rise with RAM enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ram_seg0_apply <= 1'b0;
      ram_step_rate <= 16'h0000;
      ram_end_addr <= 10'h000;
      ram_start_addr <= 10'h000;
      ram_play_mode <= 3'h0;
    end else begin
      ram_seg0_apply <= ram_en_s && rt_s && !rt_prev; // RQ21
      if (ram_en_s && rt_s && !rt_prev) begin
        ram_step_rate <= seg0[SEG_STEP_LO +: 16]; // RQ22
        ram_end_addr <= seg0[SEG_END_LO +: 10];
        ram_start_addr <= seg0[SEG_START_LO +: 10];
        ram_play_mode <= seg0[SEG_MODE_LO +: 3]; // RQ23
      end
    end
  end

  // Sync validation latch: held in reset while disabled
  always_ff @(posedge clk) begin
    if (sys_rst || cw2_act[CW2_SYNC_DIS]) begin
      sync_sample_error_pin <= 1'b0; // RQ8
    end else if (sync_check_fail) begin
      sync_sample_error_pin <= 1'b1; // RQ7
    end
  end

  // Gate polarity resolved before the assembler sees it
  logic tx_active;
  assign tx_active = gate_s ^ cw2_act[CW2_TX_INV]; // RQ6

  upcr_assembler #(.DATA_W(DATA_W)) upcr_assembler_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .word_in(word_in),
    .word_valid(word_valid),
    .tx_active(tx_active),
    .q_first(cw2_act[CW2_Q_FIRST]),
    .hold_last(cw2_act[CW2_HOLD]),
    .op_mode(mode_sync),
    .bb_i(bb_i),
    .bb_q(bb_q),
    .bb_valid(bb_valid)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_trig_rise;
    ram_en_s && rt_s && !rt_prev;
  endsequence

  a_sync_err_off: assert property (cw2_act[CW2_SYNC_DIS] |=> !sync_sample_error_pin) // RQ8
    else $error("Sync error not held low while disabled");
  a_sync_err_latch: assert property (sync_sample_error_pin && !cw2_act[CW2_SYNC_DIS]
                                     |=> sync_sample_error_pin) // RQ7
    else $error("Sync error dropped while validation enabled");
  a_seg_apply: assert property (ram_seg0_apply |-> $past(ram_en_s) && $past(rt_s)
                                && !$past(rt_prev)) // RQ21
    else $error("Segment applied without trigger rise");
  a_seg_fields: assert property (s_trig_rise |=> ram_play_mode == $past(seg0[2:0])
                                 && ram_start_addr == $past(seg0[15:6])) // RQ23
    else $error("Segment fields not taken on apply");
  a_auto_quiet: assert property (!auto_en |=> !auto_pulse) // RQ19
    else $error("Automatic update fired while disabled");
  a_upd_immed: assert property (wr_commit && addr == ADDR_UPD
                                |=> upd_interval == $past(next_shift[31:0])) // RQ18
    else $error("Interval write not effective at once");
  a_cw3_reset: assert property ($fell(sys_rst) |-> reference_output_drive == 2'h1
                                && oscillator_band_select == 3'h7 && pump_current_select == 3'h7
                                && ref_div_run && !pll_enable && pll_modulus == 7'h00) // RQ10
    else $error("Third control word reset values wrong");
  a_dac_reset: assert property ($fell(sys_rst) |-> dac_full_scale_code == 8'hFF) // RQ17
    else $error("Full-scale code reset value wrong");
  a_open_zero: assert property ((cw3_buf & ~CW3_MASK) == 32'h0 && (seg0 & ~SEG_MASK) == 48'h0) // RQ24
    else $error("Open bits hold ones");
endmodule : upcr_bank
`default_nettype wire

// ### upcr_pkg.sv
/*
  Package for the upconverter control register bank: serial addresses,
  field positions, write masks and reset values.
  Assumes nothing of its surroundings; imported by the bank and assembler.
*/
package upcr_pkg;
  // Serial instruction layout
  localparam int ADDR_W = 5;          // Address bits in the instruction byte
  localparam int INSTR_BITS = 8;      // Instruction byte length
  localparam int INSTR_RD_POS = 7;    // Read flag position
  localparam int REG_BITS = 48;       // Widest register
  // Register addresses
  localparam logic [4:0] ADDR_CW2 = 5'h01;  // Second control word
  localparam logic [4:0] ADDR_CW3 = 5'h02;  // Third control word
  localparam logic [4:0] ADDR_DAC = 5'h03;  // Full-scale code
  localparam logic [4:0] ADDR_UPD = 5'h04;  // Auto update interval
  localparam logic [4:0] ADDR_SEG0 = 5'h05; // RAM segment 0
  // Register lengths in bytes
  localparam logic [2:0] LEN_WORD = 3'h4;
  localparam logic [2:0] LEN_SEG = 3'h6;
  // Second control word fields
  localparam int CW2_AUTO_UPD = 23;   // Automatic update enable
  localparam int CW2_TX_INV = 9;      // Transmit gate polarity
  localparam int CW2_Q_FIRST = 8;     // Pairing order
  localparam int CW2_HOLD = 6;        // Hold last value
  localparam int CW2_SYNC_DIS = 5;    // Sync validation disable
  localparam logic [31:0] CW2_MASK = 32'h0080_0360;
  localparam logic [31:0] CW2_RST = 32'h0000_0020;
  // Third control word fields
  localparam int CW3_DRV_LO = 28;     // Reference output drive, 2 bits
  localparam int CW3_BAND_LO = 24;    // Oscillator band, 3 bits
  localparam int CW3_PUMP_LO = 19;    // Pump current, 3 bits
  localparam int CW3_DIV_BYP = 15;    // Input divider bypass
  localparam int CW3_DIV_RUN = 14;    // Input divider reset, active low
  localparam int CW3_PLL_EN = 8;      // PLL enable
  localparam int CW3_N_LO = 1;        // Feedback modulus, 7 bits
  localparam logic [31:0] CW3_MASK = 32'h3738_C1FE;
  localparam logic [31:0] CW3_RST = 32'h1738_4000;
  // Full-scale code register
  localparam logic [31:0] DAC_MASK = 32'h0000_00FF;
  localparam logic [31:0] DAC_RST = 32'h0000_00FF;
  // Update interval register
  localparam logic [31:0] UPD_RST = 32'h0FFF_FFFF;
  // RAM segment 0 fields
  localparam int SEG_STEP_LO = 32;    // Step rate, 16 bits
  localparam int SEG_END_LO = 22;     // End address, 10 bits
  localparam int SEG_START_LO = 6;    // Start address, 10 bits
  localparam int SEG_MODE_LO = 0;     // Playback mode, 3 bits
  localparam logic [47:0] SEG_MASK = 48'hFFFF_FFC0_FFC7;
  localparam logic [47:0] SEG_RST = 48'h0000_0000_0000;
  // Operating mode in which hold-last-value is ignored
  localparam logic [1:0] MODE_NO_HOLD = 2'h1;
endpackage : upcr_pkg

// ### upcr_assembler.sv
/*
  Baseband data assembler: pairs incoming words into I and Q and gates
  them with the transmit gate. Assumes words and gate arrive on clk,
  already synchronised, and that pairs start after the gate opens.
*/
`timescale 1ns/100ps
`default_nettype none
module upcr_assembler
  import upcr_pkg::*;
#(
  parameter int DATA_W = 18  // Sample word width
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [DATA_W-1:0] word_in,  // Incoming sample word
  input wire logic word_valid,            // Word present this cycle
  input wire logic tx_active,             // Gate resolved to transmit
  input wire logic q_first,               // Pairing order
  input wire logic hold_last,             // Hold last value
  input wire logic [1:0] op_mode,         // Operating mode of first word
  output logic [DATA_W-1:0] bb_i,         // Baseband I
  output logic [DATA_W-1:0] bb_q,         // Baseband Q
  output logic bb_valid                   // New pair this cycle
);
  // Elaboration check: a zero-width word cannot be paired
  if (DATA_W < 1) begin : g_bad_width
    $error("DATA_W must be positive");
  end

  logic second;                 // Next word closes the pair
  logic [DATA_W-1:0] first_word; // First word of the open pair
  logic hold_eff;               // Hold setting as it applies
  assign hold_eff = hold_last && (op_mode != MODE_NO_HOLD); // RQ3

  // Pair tracking; standby drops a half pair so the next burst aligns
  always_ff @(posedge clk) begin
    if (sys_rst || !tx_active) begin
      second <= 1'b0;
      first_word <= '0;
    end else if (word_valid) begin
      second <= !second;
      if (!second) begin
        first_word <= word_in;
      end
    end
  end

  // Output registers: pair order, then standby gating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bb_i <= '0;
      bb_q <= '0;
      bb_valid <= 1'b0;
    end else if (!tx_active) begin // RQ5
      bb_valid <= 1'b0;
      if (!hold_eff) begin // RQ4
        bb_i <= '0;
        bb_q <= '0;
      end
      // Else outputs keep the last accepted pair
    end else begin
      bb_valid <= word_valid && second;
      if (word_valid && second) begin
        if (q_first) begin // RQ1
          bb_q <= first_word;
          bb_i <= word_in;
        end else begin // RQ2
          bb_i <= first_word;
          bb_q <= word_in;
        end
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_standby_zero: assert property (!tx_active && !hold_eff |=> bb_i == '0 && bb_q == '0) // RQ4
    else $error("Standby without hold did not force zeros");
  a_standby_hold: assert property (!tx_active && hold_eff |=> $stable(bb_i) && $stable(bb_q)) // RQ5
    else $error("Standby with hold changed the baseband output");
  a_order_iq: assert property (tx_active && word_valid && second && !q_first
                               |=> bb_q == $past(word_in)) // RQ2
    else $error("I-first pair placed second word wrongly");
  a_order_qi: assert property (tx_active && word_valid && second && q_first
                               |=> bb_i == $past(word_in)) // RQ1
    else $error("Q-first pair placed second word wrongly");
endmodule : upcr_assembler
`default_nettype wire

// ### upcr_host.sv
/*
  Host model for the serial port: whole frames, MSB first, slow sclk.
  Assumes the bank's clk and a data line split into in, out and enable.
*/
`timescale 1ns/100ps
`default_nettype none
module upcr_host
  import upcr_pkg::*;
(
  input wire logic clk,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic drv = 1'b0; // Host owns the data line
  logic bit_q = 1'b0; // Bit the host drives
  logic idle_q = 1'b0; // Toggles so an undriven line never looks steady
  // Deselected, sclk parked low between frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
  end
  always @(posedge clk) idle_q <= ~idle_q;
  // Wire level: the bank when it drives, else the host, else a moving value
  assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_q : idle_q);
  // One frame; 5-cycle low and 6-cycle high phases keep sclk clear of the synchroniser minimum
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [47:0] wd,
                      output logic [47:0] rv);
    logic [55:0] sh;
    int n;
    n = (a == ADDR_SEG0) ? 56 : 40;
    sh = (n == 56) ? {rd, 2'h0, a, wd} : {rd, 2'h0, a, wd[31:0], 16'h0};
    rv = '0;
    cs_n_pin <= 1'b0;
    drv <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bit_q <= sh[55];
      drv <= !(rd && i >= 8);
      sh = sh << 1;
      repeat (5) @(posedge clk);
      if (i >= 8) rv = {rv[46:0], sdio_in};
      sclk_pin <= 1'b1;
      repeat (6) @(posedge clk);
      sclk_pin <= 1'b0;
    end
    repeat (6) @(posedge clk);
    cs_n_pin <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : upcr_host
`default_nettype wire

// ### test_upconverter_control_registers.sv
/*
  Testbench for the control bank: register access, update events, RAM
  segment apply, assembler and sync error latch. Assumes upcr_host.
*/
`timescale 1ns/100ps
`default_nettype none
module test_upconverter_control_registers;
  import upcr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst, cs_n_pin, sclk_pin, sdio_in, sdio_out, sdio_oe, io_update_pin;
  logic transmit_gate_pin, ram_trigger_pin, sync_sample_error_pin, ref_div_bypass;
  logic cw1_ram_enable, sync_check_fail, word_valid, bb_valid, ref_div_run, pll_enable;
  logic io_update_event, ram_seg0_apply;
  logic [1:0] cw1_op_mode, reference_output_drive;
  logic [17:0] word_in, bb_i, bb_q, ref_set;
  logic [2:0] oscillator_band_select, pump_current_select, ram_play_mode;
  logic [6:0] pll_modulus;
  logic [7:0] dac_full_scale_code;
  logic [15:0] ram_step_rate;
  logic [9:0] ram_end_addr, ram_start_addr;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0; // Hang guard count
  // All reference clock fields in one word
  assign ref_set = {reference_output_drive, oscillator_band_select, pump_current_select,
    ref_div_bypass, ref_div_run, pll_enable, pll_modulus};
  initial forever #12.5 clk = ~clk;
  upcr_bank upcr_bank_inst (.clk, .sys_rst, .cs_n_pin, .sclk_pin, .sdio_in, .sdio_out,
    .sdio_oe, .io_update_pin, .transmit_gate_pin, .ram_trigger_pin, .sync_sample_error_pin,
    .cw1_op_mode, .cw1_ram_enable, .sync_check_fail, .word_in, .word_valid, .bb_i, .bb_q,
    .bb_valid, .reference_output_drive, .oscillator_band_select, .pump_current_select,
    .ref_div_bypass, .ref_div_run, .pll_enable, .pll_modulus, .dac_full_scale_code,
    .io_update_event, .ram_seg0_apply, .ram_step_rate, .ram_end_addr, .ram_start_addr,
    .ram_play_mode);
  upcr_host upcr_host_inst (.clk, .cs_n_pin, .sclk_pin, .sdio_in, .sdio_out, .sdio_oe);
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [47:0] d);
    logic [47:0] v;
    upcr_host_inst.xfer(1'b0, a, d, v);
  endtask : wr
  task automatic rdchk(input string nm, input logic [4:0] a, input logic [47:0] exp);
    logic [47:0] v;
    upcr_host_inst.xfer(1'b1, a, 48'h0, v);
    chk(nm, v, exp);
  endtask : rdchk
  // Pin pulse long enough for the synchroniser, then outputs settle
  task automatic upd;
    io_update_pin <= 1'b1;
    repeat (6) @(posedge clk);
    io_update_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : upd
  task automatic t_reset;
    @(negedge clk);
    chk("ref fields", ref_set, 48'h1FD00);
    chk("fsc", dac_full_scale_code, 48'hFF);
    chk("sync err", sync_sample_error_pin, 48'h0);
    @(posedge clk);
    rdchk("cw3", ADDR_CW3, 48'h1738_4000);
    rdchk("interval", ADDR_UPD, 48'h0FFF_FFFF);
  endtask : t_reset
  // Open bits set on purpose; they must read back clear
  task automatic t_cw3;
    wr(ADDR_CW3, 48'hED10_BF55);
    rdchk("cw3 rb", ADDR_CW3, 48'h2510_8154);
    wr(ADDR_DAC, 48'h1234_5678);
    rdchk("dac rb", ADDR_DAC, 48'h78);
    wr(5'h1F, 48'hFFFF_FFFF);
    rdchk("unmapped", 5'h1F, 48'h0);
    upd();
    chk("ref fields", ref_set, 48'h2AAAA);
    chk("fsc", dac_full_scale_code, 48'h78);
  endtask : t_cw3
  task automatic t_seg;
    int n = 0;
    wr(ADDR_SEG0, 48'hABCD_1234_567D);
    rdchk("seg0 rb", ADDR_SEG0, 48'hABCD_1200_5645);
    ram_trigger_pin <= 1'b1;
    repeat (10) begin
      @(negedge clk);
      n += int'(ram_seg0_apply === 1'b1);
    end
    chk("apply off", n, 0);
    @(posedge clk);
    ram_trigger_pin <= 1'b0;
    cw1_ram_enable <= 1'b1;
    repeat (6) @(posedge clk);
    ram_trigger_pin <= 1'b1;
    repeat (10) begin
      @(negedge clk);
      if (ram_seg0_apply === 1'b1) break;
    end
    chk("apply", ram_seg0_apply, 48'h1);
    chk("seg fields", {ram_step_rate, ram_end_addr, ram_start_addr, ram_play_mode},
      {9'h000, 16'hABCD, 10'h048, 10'h159, 3'h5});
    @(posedge clk);
    ram_trigger_pin <= 1'b0;
  endtask : t_seg
  task automatic t_auto;
    int n = 0;
    wr(ADDR_CW2, 48'h0080_0020);
    upd();
    wr(ADDR_UPD, 48'h14);
    repeat (60) begin
      @(negedge clk);
      if (io_update_event === 1'b1) break;
    end
    repeat (60) begin
      @(negedge clk);
      n++;
      if (io_update_event === 1'b1) break;
    end
    chk("auto gap", n, 21);
    @(posedge clk);
    wr(ADDR_CW2, 48'h20);
    upd();
    n = 0;
    repeat (80) begin
      @(negedge clk);
      n += int'(io_update_event === 1'b1);
    end
    chk("auto off", n, 0);
    @(posedge clk);
  endtask : t_auto
  // One pair in transmit, then standby with ignored words
  task automatic t_asm(input logic qf, input logic hold, input logic inv,
                       input logic [1:0] md);
    logic [17:0] ei, eq;
    ei = qf ? 18'h2B00C : 18'h15A33;
    eq = qf ? 18'h15A33 : 18'h2B00C;
    wr(ADDR_CW2, {38'h0, inv, qf, 1'b0, hold, 6'h20});
    upd();
    cw1_op_mode <= md;
    transmit_gate_pin <= ~inv;
    repeat (4) @(posedge clk);
    word_valid <= 1'b1;
    word_in <= 18'h15A33;
    @(posedge clk);
    word_in <= 18'h2B00C;
    @(posedge clk);
    word_valid <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (bb_valid === 1'b1) break;
    end
    chk("pair", {bb_valid, bb_i, bb_q}, {1'b1, ei, eq});
    @(posedge clk);
    transmit_gate_pin <= inv;
    repeat (4) @(posedge clk);
    word_in <= 18'h3FFFF;
    word_valid <= 1'b1;
    repeat (2) @(posedge clk);
    word_valid <= 1'b0;
    repeat (3) @(negedge clk);
    chk("standby", {bb_i, bb_q}, (hold && md != 2'h1) ? {ei, eq} : 36'h0);
    @(posedge clk);
  endtask : t_asm
  task automatic t_sync;
    wr(ADDR_CW2, 48'h0);
    upd();
    sync_check_fail <= 1'b1;
    @(posedge clk);
    sync_check_fail <= 1'b0;
    repeat (5) @(negedge clk);
    chk("sync latched", sync_sample_error_pin, 48'h1);
    @(posedge clk);
    wr(ADDR_CW2, 48'h20);
    upd();
    @(negedge clk);
    chk("sync off", sync_sample_error_pin, 48'h0);
  endtask : t_sync
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // Whole run is near 9000 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    sys_rst = 1'b1;
    io_update_pin = 1'b0;
    transmit_gate_pin = 1'b0;
    ram_trigger_pin = 1'b0;
    cw1_op_mode = 2'h0;
    cw1_ram_enable = 1'b0;
    sync_check_fail = 1'b0;
    word_in = 18'h0;
    word_valid = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_cw3();
    t_seg();
    t_auto();
    t_asm(1'b0, 1'b0, 1'b0, 2'h0);
    t_asm(1'b1, 1'b1, 1'b1, 2'h0);
    t_asm(1'b1, 1'b1, 1'b0, 2'h1);
    t_sync();
    close_out();
  end
endmodule : test_upconverter_control_registers
`default_nettype wire
